// File: iefr_top.sv
// iefr_top.sv: interrupt enable/flag register with core request and event interrupt
//
// Contract
// - software reads and writes the control register; reads return enables and flags.
// - register holds enables of all sources but the comparator, and flags of the timer, pin and port sources only.
// - a flag sets on its condition even while its own enable is clear.
// - flag setting ignores the global enable, which sits at bit 7.
`timescale 1ns/1ns
`default_nettype none

module iefr_top (
  input  wire logic                         CLOCK,        // 20 MHz core clock
  input  wire logic                         RST,          // synchronous reset, high
  input  wire logic [iefr_pkg::ADDR_W-1:0]  ADDR,         // register address
  input  wire logic [iefr_pkg::DATA_W-1:0]  WDATA,        // write data
  input  wire logic                         WR,           // write strobe
  input  wire logic                         RD,           // read strobe
  output logic      [iefr_pkg::DATA_W-1:0]  RDATA,        // read data, cycle after RD
  input  wire logic                         TMR_OVF_EVT,  // main_timer overflow pulse
  input  wire logic                         EXT_PIN_EVT,  // external pin edge pulse
  input  wire logic                         PORT_CHG_EVT, // port change pulse
  input  wire logic                         PERIPH_IRQ,   // other peripherals pending
  output logic                              CORE_IRQ,     // request to the core
  output logic                              EVT_IRQ       // unmasked event status set
);
  // -------------------------------------------------------------------------
  // register state
  // -------------------------------------------------------------------------
  logic [iefr_pkg::DATA_W-1:0] intctl_q;
  logic [iefr_pkg::DATA_W-1:0] intctl_d;
  logic [iefr_pkg::DATA_W-1:0] rdata_q;
  logic [iefr_pkg::EVT_W-1:0]  evt_status;
  logic [iefr_pkg::EVT_W-1:0]  evt_mask;
  logic [iefr_pkg::EVT_W-1:0]  evt_pulse;
  logic                        wr_intctl;
  logic                        wr_status;
  logic                        wr_mask;

  function automatic logic hit(input logic strobe, input logic [iefr_pkg::ADDR_W-1:0] a,
                               input logic [iefr_pkg::ADDR_W-1:0] reg_addr);
    hit = strobe && (a == reg_addr);
  endfunction

  assign wr_intctl = hit(WR, ADDR, iefr_pkg::ADDR_INTCTL);
  assign wr_status = hit(WR, ADDR, iefr_pkg::ADDR_EVT_STATUS);
  assign wr_mask   = hit(WR, ADDR, iefr_pkg::ADDR_EVT_MASK);

  // -------------------------------------------------------------------------
  // interrupt_control: enables and flags in one byte
  // -------------------------------------------------------------------------
  // the comparator's enable and flag live elsewhere, so only three flag sources here
  always_comb begin
    intctl_d = intctl_q;
    if (wr_intctl) begin
      intctl_d = WDATA;
    end
    // no enable term on purpose: flags latch whatever the enables say
    if (TMR_OVF_EVT) begin
      intctl_d[iefr_pkg::BIT_TMR_OVF_FLG] = 1'b1;
    end
    if (EXT_PIN_EVT) begin
      intctl_d[iefr_pkg::BIT_EXT_PIN_FLG] = 1'b1;
    end
    if (PORT_CHG_EVT) begin
      intctl_d[iefr_pkg::BIT_PORT_CHG_FLG] = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      intctl_q <= iefr_pkg::INTCTL_RESET;
    end else begin
      intctl_q <= intctl_d;
    end
  end

  // -------------------------------------------------------------------------
  // core request
  // -------------------------------------------------------------------------
  always_comb begin
    CORE_IRQ = intctl_q[iefr_pkg::BIT_GLOBAL_EN] && (
      (intctl_q[iefr_pkg::BIT_TMR_OVF_EN]  && intctl_q[iefr_pkg::BIT_TMR_OVF_FLG])  ||
      (intctl_q[iefr_pkg::BIT_EXT_PIN_EN]  && intctl_q[iefr_pkg::BIT_EXT_PIN_FLG])  ||
      (intctl_q[iefr_pkg::BIT_PORT_CHG_EN] && intctl_q[iefr_pkg::BIT_PORT_CHG_FLG]) ||
      (intctl_q[iefr_pkg::BIT_PERIPH_EN]   && PERIPH_IRQ));
  end

  // -------------------------------------------------------------------------
  // event status and mask
  // -------------------------------------------------------------------------
  always_comb begin
    evt_pulse = '0;
    evt_pulse[iefr_pkg::EVT_TMR_OVF]  = TMR_OVF_EVT;
    evt_pulse[iefr_pkg::EVT_EXT_PIN]  = EXT_PIN_EVT;
    evt_pulse[iefr_pkg::EVT_PORT_CHG] = PORT_CHG_EVT;
  end

  iefr_evt_status #(
    .WIDTH      (iefr_pkg::EVT_W)
  ) u_evt (
    .clk        (CLOCK),
    .rst        (RST),
    .set_pulse  (evt_pulse),
    .clr_we     (wr_status),
    .clr_bits   (WDATA[iefr_pkg::EVT_W-1:0]),
    .mask_we    (wr_mask),
    .mask_wdata (WDATA[iefr_pkg::EVT_W-1:0]),
    .status_q   (evt_status),
    .mask_q     (evt_mask),
    .irq        (EVT_IRQ)
  );

  // -------------------------------------------------------------------------
  // read port
  // -------------------------------------------------------------------------
  // data stand only in the cycle after the strobe; zero otherwise and when unmapped
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata_q <= iefr_pkg::RDATA_IDLE;
    end else if (RD) begin
      case (ADDR)
        iefr_pkg::ADDR_INTCTL:     rdata_q <= intctl_q;
        iefr_pkg::ADDR_EVT_STATUS: rdata_q <= {{(iefr_pkg::DATA_W-iefr_pkg::EVT_W){1'b0}},
                                               evt_status};
        iefr_pkg::ADDR_EVT_MASK:   rdata_q <= {{(iefr_pkg::DATA_W-iefr_pkg::EVT_W){1'b0}},
                                               evt_mask};
        default:                   rdata_q <= iefr_pkg::RDATA_IDLE;
      endcase
    end else begin
      rdata_q <= iefr_pkg::RDATA_IDLE;
    end
  end

  assign RDATA = rdata_q;

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  property p_read_intctl;
    RD && ADDR == iefr_pkg::ADDR_INTCTL |=> RDATA == $past(intctl_q);
  endproperty
  a_read_intctl: assert property (p_read_intctl)
    else $error("control read returned wrong data");

  property p_write_intctl;
    wr_intctl && !TMR_OVF_EVT && !EXT_PIN_EVT && !PORT_CHG_EVT
      |=> intctl_q == $past(WDATA);
  endproperty
  a_write_intctl: assert property (p_write_intctl)
    else $error("control write not stored");

  property p_port_flag;
    PORT_CHG_EVT |=> intctl_q[iefr_pkg::BIT_PORT_CHG_FLG] ##1 1'b1;
  endproperty
  a_port_flag: assert property (p_port_flag)
    else $error("port change flag not set");

  property p_tmr_flag_no_enable;
    TMR_OVF_EVT && !intctl_q[iefr_pkg::BIT_TMR_OVF_EN]
      |=> intctl_q[iefr_pkg::BIT_TMR_OVF_FLG];
  endproperty
  a_tmr_flag_no_enable: assert property (p_tmr_flag_no_enable)
    else $error("timer flag missed with enable clear");

  property p_ext_flag_no_global;
    EXT_PIN_EVT && !intctl_q[iefr_pkg::BIT_GLOBAL_EN]
      |=> intctl_q[iefr_pkg::BIT_EXT_PIN_FLG] && (!CORE_IRQ || intctl_q[iefr_pkg::BIT_GLOBAL_EN]);
  endproperty
  a_ext_flag_no_global: assert property (p_ext_flag_no_global)
    else $error("pin flag missed or request without global enable");

  property p_irq_needs_global;
    !intctl_q[iefr_pkg::BIT_GLOBAL_EN] |-> !CORE_IRQ;
  endproperty
  a_irq_needs_global: assert property (p_irq_needs_global)
    else $error("core request with global enable clear");

  property p_irq_on_enabled_flag;
    wr_intctl && WDATA == 8'hA4 |=> CORE_IRQ;
  endproperty
  a_irq_on_enabled_flag: assert property (p_irq_on_enabled_flag)
    else $error("no core request for enabled pending timer flag");

  property p_evt_sticky;
    TMR_OVF_EVT |=> evt_status[iefr_pkg::EVT_TMR_OVF] [*2] or
                    (evt_status[iefr_pkg::EVT_TMR_OVF] ##1 $past(wr_status));
  endproperty
  a_evt_sticky: assert property (p_evt_sticky)
    else $error("event status not sticky");

  property p_read_idle;
    !RD |=> RDATA == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data outside read slot");

  // software clearing a flag must not swallow an event of the same cycle
  property p_flag_set_wins;
    wr_intctl && EXT_PIN_EVT |=> intctl_q[iefr_pkg::BIT_EXT_PIN_FLG];
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins)
    else $error("pin flag lost to a same-cycle write");

  property p_status_w1c;
    wr_status && WDATA[iefr_pkg::EVT_TMR_OVF] && !TMR_OVF_EVT
      |=> !evt_status[iefr_pkg::EVT_TMR_OVF];
  endproperty
  a_status_w1c: assert property (p_status_w1c)
    else $error("timer status not cleared by a one");

  property p_mask_write;
    wr_mask |=> {5'h00, evt_mask} == ($past(WDATA) & 8'h07);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write not stored");

  c_core_irq: cover property (wr_intctl ##1 CORE_IRQ);
  c_flag_disabled: cover property (TMR_OVF_EVT && !intctl_q[iefr_pkg::BIT_GLOBAL_EN]);
  c_set_over_clear: cover property (wr_intctl && EXT_PIN_EVT && !WDATA[1]);
  c_evt_irq: cover property (EVT_IRQ ##1 wr_status ##1 !EVT_IRQ);
endmodule

`default_nettype wire

// File: iefr_pkg.sv
// iefr_pkg.sv: constants for the interrupt enable/flag register and its event-status helper
`default_nettype none

package iefr_pkg;
  // -------------------------------------------------------------------------
  // bus geometry
  // -------------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;

  // -------------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_INTCTL     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_EVT_MASK   = 8'h02;

  // -------------------------------------------------------------------------
  // interrupt_control field positions
  // -------------------------------------------------------------------------
  localparam int BIT_GLOBAL_EN   = 7;
  localparam int BIT_PERIPH_EN   = 6;
  localparam int BIT_TMR_OVF_EN  = 5;
  localparam int BIT_EXT_PIN_EN  = 4;
  localparam int BIT_PORT_CHG_EN = 3;
  localparam int BIT_TMR_OVF_FLG = 2;
  localparam int BIT_EXT_PIN_FLG = 1;
  localparam int BIT_PORT_CHG_FLG = 0;

  // -------------------------------------------------------------------------
  // event-status layout and reset values
  // -------------------------------------------------------------------------
  localparam int EVT_W        = 3;
  localparam int EVT_TMR_OVF  = 0;
  localparam int EVT_EXT_PIN  = 1;
  localparam int EVT_PORT_CHG = 2;

  localparam logic [DATA_W-1:0] INTCTL_RESET   = 8'h00;
  localparam logic [EVT_W-1:0]  EVT_MASK_RESET = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_IDLE     = 8'h00;
endpackage

`default_nettype wire

// File: iefr_evt_status.sv
// iefr_evt_status.sv: sticky event status with write-one-to-clear and a mask
`timescale 1ns/1ns
`default_nettype none

module iefr_evt_status #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,         // core clock
  input  wire logic             rst,         // synchronous reset, high
  input  wire logic [WIDTH-1:0] set_pulse,   // one-cycle events
  input  wire logic             clr_we,      // status write strobe
  input  wire logic [WIDTH-1:0] clr_bits,    // ones clear status bits
  input  wire logic             mask_we,     // mask write strobe
  input  wire logic [WIDTH-1:0] mask_wdata,  // new mask value
  output logic      [WIDTH-1:0] status_q,    // sticky status
  output logic      [WIDTH-1:0] mask_q,      // mask, one enables
  output logic                  irq          // level, unmasked status set
);
  logic [WIDTH-1:0] status_d;

  // set wins over a clear landing in the same cycle
  always_comb begin
    status_d = status_q;
    if (clr_we) begin
      status_d = status_q & ~clr_bits;
    end
    status_d = status_d | set_pulse;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= WIDTH'(iefr_pkg::EVT_MASK_RESET);
    end else if (mask_we) begin
      mask_q <= mask_wdata;
    end
  end

  assign irq = |(status_q & mask_q);
endmodule

`default_nettype wire

// File: iefr_src_model.sv
// iefr_src_model.sv: behavioural interrupt sources and peripheral request line
`timescale 1ns/1ns
`default_nettype none

module iefr_src_model (
  input  wire logic clk,          // core clock
  output logic      tmr_ovf_evt,  // timer overflow pulse
  output logic      ext_pin_evt,  // external pin pulse
  output logic      port_chg_evt, // port change pulse
  output logic      periph_irq    // other peripherals pending
);
  initial begin
    tmr_ovf_evt  = 1'b0;
    ext_pin_evt  = 1'b0;
    port_chg_evt = 1'b0;
    periph_irq   = 1'b0;
  end

  // -------------------------------------------------------------------------
  // source behaviour
  // -------------------------------------------------------------------------
  // called just after an edge: the next edge takes the pulse, then it drops
  task automatic pulse(input logic [2:0] which);
    tmr_ovf_evt  <= which[0];
    ext_pin_evt  <= which[1];
    port_chg_evt <= which[2];
    @(posedge clk);
    tmr_ovf_evt  <= 1'b0;
    ext_pin_evt  <= 1'b0;
    port_chg_evt <= 1'b0;
  endtask

  // level request, held until changed
  task automatic set_periph(input logic lvl);
    periph_irq <= lvl;
  endtask
endmodule

`default_nettype wire

// File: tb_top.sv
// tb_top.sv: self-checking bench for the interrupt enable/flag register
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic       CLOCK;
  logic       RST;
  logic [7:0] ADDR;
  logic [7:0] WDATA;
  logic       WR;
  logic       RD;
  logic [7:0] RDATA;
  logic       tmr_evt;
  logic       pin_evt;
  logic       chg_evt;
  logic       periph;
  logic       CORE_IRQ;
  logic       EVT_IRQ;
  int         num_errors;
  int         compares;
  // exp in bit 9, peripheral level in bit 8, control value below
  logic [9:0] tab [9] = '{10'h024, 10'h2A4, 10'h0A0, 10'h289, 10'h052,
                          10'h2D2, 10'h3C0, 10'h140, 10'h180};

  initial CLOCK = 1'b0;
  always #25 CLOCK = ~CLOCK;

  iefr_src_model src (.clk(CLOCK), .tmr_ovf_evt(tmr_evt), .ext_pin_evt(pin_evt),
                      .port_chg_evt(chg_evt), .periph_irq(periph));

  iefr_top DUT (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
                .RDATA(RDATA), .TMR_OVF_EVT(tmr_evt), .EXT_PIN_EVT(pin_evt),
                .PORT_CHG_EVT(chg_evt), .PERIPH_IRQ(periph), .CORE_IRQ(CORE_IRQ),
                .EVT_IRQ(EVT_IRQ));

  // -------------------------------------------------------------------------
  // bus and compare tasks
  // -------------------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLOCK);
    WR    <= 1'b0;
    @(posedge CLOCK);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLOCK);
    RD   <= 1'b0;
    #1;
    check(RDATA, exp, what);
    @(posedge CLOCK);
  endtask

  // outputs are combinational: read them only once the edge has settled,
  // so the value is taken inside the task and not at the call
  task automatic irq_chk(input logic sel_evt, input logic exp, input string what);
    #1;
    check({7'h00, (sel_evt ? EVT_IRQ : CORE_IRQ)}, {7'h00, exp}, what);
    @(posedge CLOCK);
  endtask

  task automatic print_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // -------------------------------------------------------------------------
  // tests
  // -------------------------------------------------------------------------
  initial begin
    ADDR = 8'h00; WDATA = 8'h00; WR = 1'b0; RD = 1'b0; RST = 1'b1;
    num_errors = 0; compares = 0;
    repeat (8) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    rd(iefr_pkg::ADDR_INTCTL, iefr_pkg::INTCTL_RESET, "ctl reset");
    rd(iefr_pkg::ADDR_EVT_STATUS, 8'h00, "status reset");
    rd(iefr_pkg::ADDR_EVT_MASK, {5'h00, iefr_pkg::EVT_MASK_RESET}, "mask reset");
    wr(8'h05, 8'hFF);
    rd(8'h05, iefr_pkg::RDATA_IDLE, "unmapped");
    wr(iefr_pkg::ADDR_INTCTL, 8'hFF);
    rd(iefr_pkg::ADDR_INTCTL, 8'hFF, "all ctl bits rw");
    wr(iefr_pkg::ADDR_INTCTL, 8'h00);
    rd(iefr_pkg::ADDR_INTCTL, 8'h00, "ctl cleared");
    // every enable and the global enable clear, still all flags latch
    src.pulse(3'b111);
    rd(iefr_pkg::ADDR_INTCTL, 8'h07, "flags while disabled");
    irq_chk(1'b0, 1'b0, "no request while disabled");
    rd(iefr_pkg::ADDR_EVT_STATUS, 8'h07, "status latched");
    for (int i = 0; i < 9; i++) begin
      src.set_periph(tab[i][8]);
      wr(iefr_pkg::ADDR_INTCTL, tab[i][7:0]);
      irq_chk(1'b0, tab[i][9], "request gating");
    end
    src.set_periph(1'b0);
    wr(iefr_pkg::ADDR_INTCTL, 8'hA0);
    irq_chk(1'b0, 1'b0, "enabled, no flag");
    src.pulse(3'b001);
    irq_chk(1'b0, 1'b1, "timer flag requests");
    wr(iefr_pkg::ADDR_EVT_MASK, 8'h01);
    irq_chk(1'b1, 1'b1, "unmasked status");
    wr(iefr_pkg::ADDR_EVT_MASK, 8'h00);
    irq_chk(1'b1, 1'b0, "masked status");
    wr(iefr_pkg::ADDR_EVT_MASK, 8'h07);
    rd(iefr_pkg::ADDR_EVT_MASK, 8'h07, "mask readback");
    wr(iefr_pkg::ADDR_EVT_STATUS, 8'h01);
    rd(iefr_pkg::ADDR_EVT_STATUS, 8'h06, "one bit cleared");
    irq_chk(1'b1, 1'b1, "others still set");
    wr(iefr_pkg::ADDR_EVT_STATUS, 8'h06);
    rd(iefr_pkg::ADDR_EVT_STATUS, 8'h00, "all cleared");
    irq_chk(1'b1, 1'b0, "irq drops");
    // event and clearing write land on the same edge: the event wins
    fork
      wr(iefr_pkg::ADDR_INTCTL, 8'h00);
      src.pulse(3'b010);
    join
    rd(iefr_pkg::ADDR_INTCTL, 8'h02, "flag set beats clear");
    fork
      wr(iefr_pkg::ADDR_EVT_STATUS, 8'h02);
      src.pulse(3'b010);
    join
    rd(iefr_pkg::ADDR_EVT_STATUS, 8'h02, "status set beats clear");
    print_verdict();
  end

  // whole run is under a hundred cycles; this bound only catches a hang
  initial begin
    repeat (3000) @(posedge CLOCK);
    num_errors++;
    print_verdict();
  end
endmodule

`default_nettype wire
